// file: bench/sis_host_model.sv
`timescale 1ns/1ns
module sis_host_model
	import sis_pkg::*;
(
	// clock
	input  wire logic       sys_clk,
	// register request and answer
	output sis_req_t        reg_req,
	input  wire logic [7:0] reg_rdata_ff
);
	// ------------------------------------------------------------
	// host side of the register port
	// ------------------------------------------------------------
	// idle bus at time zero
	initial begin
		reg_req = '0;
	end

	// one-cycle read; released fields flip so stale values never match
	task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_req.addr = a;
		reg_req.rd = 1'b1;
		@(posedge sys_clk);
		#1;
		d = reg_rdata_ff;
		reg_req.rd = 1'b0;
		reg_req.addr = ~a;
	endtask

	// one-cycle write, data flipped after release
	task automatic reg_write(input logic [6:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1;
		reg_req.addr = a;
		reg_req.wdata = v;
		reg_req.wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_req.wr = 1'b0;
		reg_req.addr = ~a;
		reg_req.wdata = ~v;
	endtask
endmodule

// file: bench/sis_irq_status_tb.sv
`timescale 1ns/1ns
module sis_irq_status_tb
	import sis_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic       sys_clk;
	logic       rstn;
	sis_flags_t flags;
	logic       invalid_flag;
	logic       chstat_changed_flag;
	logic       transfer_error_flag;
	sis_req_t   reg_req;
	logic [7:0] reg_rdata_ff;
	logic       irq_n_ff;
	logic [7:0] d;
	int         i;
	int         bad_count;
	int         checked;
	int         cycles;
	// cause bit expected for each event kind of fire()
	int         cbit [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 4, 7};

	sis_irq_status dut (
		.sys_clk(sys_clk), .rstn(rstn), .rx_flags(flags),
		.invalid_flag(invalid_flag),
		.chstat_changed_flag(chstat_changed_flag),
		.transfer_error_flag(transfer_error_flag),
		.reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
		.irq_n_ff(irq_n_ff)
	);
	sis_host_model host (
		.sys_clk(sys_clk), .reg_req(reg_req),
		.reg_rdata_ff(reg_rdata_ff)
	);

	// ------------------------------------------------------------
	// clock, watchdog, checks
	// ------------------------------------------------------------
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// tests take about 150 cycles; a hang stops at 3000, about twenty times that
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_irq(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one event of kind k; level sources pulse for one cycle
	task automatic fire(input int k);
		@(posedge sys_clk);
		#1;
		case (k)
			0: flags.unlock_flag = ~flags.unlock_flag;
			1: invalid_flag = 1'b1;
			2: chstat_changed_flag = 1'b1;
			3: transfer_error_flag = 1'b1;
			4: flags.nonlinear_bit = ~flags.nonlinear_bit;
			5: flags.copy_permit_bit = ~flags.copy_permit_bit;
			6: flags.preemph_bit = ~flags.preemph_bit;
			7: flags.recovered_rate_code[0] = ~flags.recovered_rate_code[0];
			8: flags.sync_detect = ~flags.sync_detect;
			default: flags.recovered_rate_code[1] = ~flags.recovered_rate_code[1];
		endcase
		@(posedge sys_clk);
		#1;
		invalid_flag = 1'b0;
		chstat_changed_flag = 1'b0;
		transfer_error_flag = 1'b0;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		flags = '{unlock_flag: 1'b1, recovered_rate_code: SIS_RATE_48K,
			default: 1'b0};
		invalid_flag = 1'b0;
		chstat_changed_flag = 1'b0;
		transfer_error_flag = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		cmp_irq(irq_n_ff, 1'b1);
		host.reg_read(SIS_ADDR_MASK, d);
		cmp_reg(d, 8'h00);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h00);
		host.reg_read(SIS_ADDR_STATUS, d);
		cmp_reg(d, 8'h60);
		end_test("reset");
		// each event sets the cause bit given in cbit (kinds 8 and 9 share bits 4 and 7), read clears it
		for (i = 0; i < 10; i++) begin
			fire(i);
			cmp_irq(irq_n_ff, 1'b0);
			host.reg_read(SIS_ADDR_CAUSE, d);
			cmp_reg(d, 8'h01 << cbit[i]);
			cmp_irq(irq_n_ff, 1'b1);
			host.reg_read(SIS_ADDR_STATUS, d);
			cmp_reg(d, {1'b0, flags});
		end
		end_test("causes");
		// every rate code shows in the status register
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			#1;
			flags.recovered_rate_code = 2'(i);
			host.reg_read(SIS_ADDR_STATUS, d);
			cmp_reg(d, {1'b0, flags});
		end
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h80);
		end_test("rates");
		// all masked: no cause, no interrupt
		host.reg_write(SIS_ADDR_MASK, 8'hFF);
		for (i = 0; i < 10; i++) begin
			fire(i);
			cmp_irq(irq_n_ff, 1'b1);
		end
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h00);
		host.reg_read(SIS_ADDR_MASK, d);
		cmp_reg(d, 8'hFF);
		host.reg_write(SIS_ADDR_MASK, 8'h00);
		end_test("masked");
		// read-only and unmapped places
		host.reg_write(SIS_ADDR_CAUSE, 8'hFF);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h00);
		host.reg_read(7'h7F, d);
		cmp_reg(d, 8'h00);
		end_test("refused");
		// masking a pending cause hides the interrupt only
		fire(5);
		cmp_irq(irq_n_ff, 1'b0);
		host.reg_write(SIS_ADDR_MASK, 8'h20);
		@(posedge sys_clk);
		#1;
		cmp_irq(irq_n_ff, 1'b1);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h20);
		host.reg_write(SIS_ADDR_MASK, 8'h00);
		end_test("late mask");
		// causes collect until read; a read-cycle event still sets
		fire(5);
		fire(7);
		cmp_irq(irq_n_ff, 1'b0);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'hA0);
		fork
			host.reg_read(SIS_ADDR_CAUSE, d);
			begin
				@(posedge sys_clk);
				#1;
				invalid_flag = 1'b1;
				@(posedge sys_clk);
				#1;
				invalid_flag = 1'b0;
			end
		join
		cmp_reg(d, 8'h00);
		cmp_irq(irq_n_ff, 1'b0);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h02);
		cmp_irq(irq_n_ff, 1'b1);
		end_test("sticky");
		// reset in mid-run drops pending causes and the mask
		fire(5);
		host.reg_write(SIS_ADDR_MASK, 8'h0F);
		cmp_irq(irq_n_ff, 1'b0);
		@(posedge sys_clk);
		#1;
		rstn = 1'b0;
		@(posedge sys_clk);
		#1;
		rstn = 1'b1;
		cmp_irq(irq_n_ff, 1'b1);
		host.reg_read(SIS_ADDR_MASK, d);
		cmp_reg(d, 8'h00);
		host.reg_read(SIS_ADDR_CAUSE, d);
		cmp_reg(d, 8'h00);
		end_test("mid reset");
		print_verdict();
	end
endmodule

// file: common/sis_pkg.sv
package sis_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          SIS_AW          = 7;
	localparam logic [6:0]  SIS_ADDR_MASK   = 7'h0A;
	localparam logic [6:0]  SIS_ADDR_CAUSE  = 7'h0B;
	localparam logic [6:0]  SIS_ADDR_STATUS = 7'h0C;

	// ----------------------------------------------------------------
	// reset values and the unmapped read value
	// ----------------------------------------------------------------
	localparam logic [7:0]  SIS_MASK_RST    = 8'h00;
	localparam logic [7:0]  SIS_CAUSE_RST   = 8'h00;
	localparam logic [7:0]  SIS_RDATA_RST   = 8'h00;
	localparam logic [7:0]  SIS_UNMAPPED    = 8'h00;

	// ----------------------------------------------------------------
	// cause bit positions
	// ----------------------------------------------------------------
	localparam int          SIS_C_LOCK      = 0;
	localparam int          SIS_C_INVALID   = 1;
	localparam int          SIS_C_CHSTAT    = 2;
	localparam int          SIS_C_TERR      = 3;
	localparam int          SIS_C_NONLIN    = 4;
	localparam int          SIS_C_COPY      = 5;
	localparam int          SIS_C_EMPH      = 6;
	localparam int          SIS_C_RATE      = 7;

	// ----------------------------------------------------------------
	// status flag positions (bit 7 of status reads zero)
	// ----------------------------------------------------------------
	localparam int          SIS_F_NONLIN    = 0;
	localparam int          SIS_F_SYNC      = 1;
	localparam int          SIS_F_COPY      = 2;
	localparam int          SIS_F_EMPH      = 3;
	localparam int          SIS_F_RATE_LO   = 4;
	localparam int          SIS_F_RATE_HI   = 5;
	localparam int          SIS_F_UNLOCK    = 6;
	localparam int          SIS_FLAG_W      = 7;

	// ----------------------------------------------------------------
	// recovered rate codes
	// ----------------------------------------------------------------
	localparam logic [1:0]  SIS_RATE_192K   = 2'h0;
	localparam logic [1:0]  SIS_RATE_96K    = 2'h1;
	localparam logic [1:0]  SIS_RATE_48K    = 2'h2;
	localparam logic [1:0]  SIS_RATE_32K    = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// packed so that the bit order equals the status layout
	typedef struct packed {
		logic       unlock_flag;
		logic [1:0] recovered_rate_code;
		logic       preemph_bit;
		logic       copy_permit_bit;
		logic       sync_detect;
		logic       nonlinear_bit;
	} sis_flags_t;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [SIS_AW-1:0] addr;
		logic [7:0]        wdata;
	} sis_req_t;

endpackage

// file: hdl/sis_change_det.sv
`timescale 1ns/1ns
module sis_change_det #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// watched flags and their toggles
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] change
);

	logic [WIDTH-1:0] prev_ff;
	logic             primed_ff;

	// ----------------------------------------------------------------
	// previous-cycle copy
	// ----------------------------------------------------------------
	// primed blocks a false toggle on the first cycle after reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_ff   <= '0;
			primed_ff <= 1'b0;
		end else begin
			prev_ff   <= din;
			primed_ff <= 1'b1;
		end
	end

	// any difference from last cycle is a toggle
	assign change = primed_ff ? (din ^ prev_ff) : '0;

endmodule

// file: hdl/sis_irq_status.sv
// Operation
// RULE1 - cause bit 0 set by a toggle of the lock indication
// RULE2 - cause bit 1 set by the invalid-sample indication
// RULE3 - cause bit 2 set by the channel-status-updated indication
// RULE4 - cause bit 3 set by the transfer error indication
// RULE5 - cause bit 4 set by a toggle of nonlinear bit or sync detect
// RULE6 - cause bit 5 set by a toggle of the copy permission bit
// RULE7 - cause bit 6 set by a toggle of the pre-emphasis bit
// RULE8 - cause bit 7 set by a change of the rate code
// RULE9 - status bit 0 mirrors channel-status bit 1, nonlinear audio
// RULE10 - status bit 1 reads 1 while burst sync code is detected
// RULE11 - status bit 2 mirrors channel-status bit 2, copy permission
// RULE12 - status bit 3 mirrors channel-status bit 3, pre-emphasis
// RULE13 - masked events neither set cause nor interrupt; reset unmasked
// RULE14 - lock indication is 1 while unlocked, its toggles feed bit 0
// RULE15 - rate code 00 192k, 01 96/88.2k, 10 48/44.1k, 11 32k
// RULE16 - pre-emphasis value is 1 when data carries pre-emphasis
// RULE17 - interrupt low while unmasked cause set; cause read clears it
// RULE18 - a flag change is any difference from last cycle's value
`timescale 1ns/1ns
module sis_irq_status
	import sis_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// receiver flags, same clock domain
	input  wire sis_flags_t rx_flags,
	input  wire logic       invalid_flag,
	input  wire logic       chstat_changed_flag,
	input  wire logic       transfer_error_flag,
	// register access from the control interface
	input  wire sis_req_t   reg_req,
	output logic [7:0]      reg_rdata_ff,
	// interrupt, active low
	output logic            irq_n_ff
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic is_read(input sis_req_t r,
		input logic [SIS_AW-1:0] a);
		return r.rd && (r.addr == a);
	endfunction

	logic [7:0]            mask_ff;
	logic [7:0]            cause_ff;
	logic [7:0]            nxt_mask;
	logic [7:0]            nxt_cause;
	logic [7:0]            nxt_rdata;
	logic [7:0]            ev;
	logic [7:0]            status_word;
	logic [SIS_FLAG_W-1:0] chg;
	logic                  rd_mask;
	logic                  rd_cause;
	logic                  rd_status;
	logic                  wr_mask;
	logic                  live_ff;

	assign rd_mask   = is_read(reg_req, SIS_ADDR_MASK);
	assign rd_cause  = is_read(reg_req, SIS_ADDR_CAUSE);
	assign rd_status = is_read(reg_req, SIS_ADDR_STATUS);
	assign wr_mask   = reg_req.wr && (reg_req.addr == SIS_ADDR_MASK);

	// ----------------------------------------------------------------
	// toggle detection
	// ----------------------------------------------------------------
	// RULE18 compare with previous cycle
	sis_change_det #(
		.WIDTH (SIS_FLAG_W)
	) u_chg (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.din     (rx_flags),
		.change  (chg)
	);

	// ----------------------------------------------------------------
	// event vector
	// ----------------------------------------------------------------
	// RULE1 lock toggle event
	// RULE14 unlock level watched
	assign ev[SIS_C_LOCK]    = chg[SIS_F_UNLOCK];
	// RULE2 invalid level event
	assign ev[SIS_C_INVALID] = invalid_flag;
	// RULE3 channel status update
	assign ev[SIS_C_CHSTAT]  = chstat_changed_flag;
	// RULE4 transfer error event
	assign ev[SIS_C_TERR]    = transfer_error_flag;
	// RULE5 nonlinear or sync toggle
	assign ev[SIS_C_NONLIN]  = chg[SIS_F_NONLIN] | chg[SIS_F_SYNC];
	// RULE6 copy permission toggle
	assign ev[SIS_C_COPY]    = chg[SIS_F_COPY];
	// RULE7 pre-emphasis toggle
	assign ev[SIS_C_EMPH]    = chg[SIS_F_EMPH];
	// RULE8 rate code change
	assign ev[SIS_C_RATE]    = chg[SIS_F_RATE_LO] | chg[SIS_F_RATE_HI];

	// ----------------------------------------------------------------
	// cause and mask next state
	// ----------------------------------------------------------------
	// RULE13 masked events dropped
	// RULE17 read clears, a same-cycle event still sets
	assign nxt_cause = (rd_cause ? SIS_CAUSE_RST : cause_ff)
		| (ev & ~mask_ff);
	assign nxt_mask  = wr_mask ? reg_req.wdata : mask_ff;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// RULE9 nonlinear bit at 0
	// RULE10 sync detect at 1
	// RULE11 copy permission at 2
	// RULE12 pre-emphasis at 3
	// RULE15 rate code at 5:4, passed as received
	// RULE16 pre-emphasis level kept as received
	assign status_word = {1'b0, rx_flags};
	// rdata holds between reads so a slow host can sample it
	assign nxt_rdata = rd_cause  ? cause_ff    :
	                   rd_status ? status_word :
	                   rd_mask   ? mask_ff     :
	                   reg_req.rd ? SIS_UNMAPPED : reg_rdata_ff;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// RULE13 all unmasked at reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mask_ff      <= SIS_MASK_RST;
			cause_ff     <= SIS_CAUSE_RST;
			reg_rdata_ff <= SIS_RDATA_RST;
		end else begin
			mask_ff      <= nxt_mask;
			cause_ff     <= nxt_cause;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// RULE17 interrupt from unmasked causes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_n_ff <= 1'b1;
			live_ff  <= 1'b0;
		end else begin
			irq_n_ff <= ~|(nxt_cause & ~mask_ff);
			live_ff  <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	lock_cause_a: assert property ( // RULE1
		live_ff && $changed(rx_flags.unlock_flag) && !mask_ff[SIS_C_LOCK]
		|=> cause_ff[SIS_C_LOCK] ##0 !irq_n_ff)
		else $error("lock toggle did not set cause 0");

	invalid_cause_a: assert property ( // RULE2
		invalid_flag && !mask_ff[SIS_C_INVALID] |=> cause_ff[SIS_C_INVALID])
		else $error("invalid flag did not set cause 1");

	chstat_cause_a: assert property ( // RULE3
		chstat_changed_flag && !mask_ff[SIS_C_CHSTAT]
		|=> cause_ff[SIS_C_CHSTAT])
		else $error("status update did not set cause 2");

	terr_cause_a: assert property ( // RULE4
		transfer_error_flag && !mask_ff[SIS_C_TERR] |=> cause_ff[SIS_C_TERR])
		else $error("transfer error did not set cause 3");

	nonlin_cause_a: assert property ( // RULE5
		live_ff && !mask_ff[SIS_C_NONLIN]
		&& ($changed(rx_flags.nonlinear_bit)
		|| $changed(rx_flags.sync_detect))
		|=> cause_ff[SIS_C_NONLIN])
		else $error("nonlinear toggle did not set cause 4");

	copy_cause_a: assert property ( // RULE6
		live_ff && $changed(rx_flags.copy_permit_bit)
		&& !mask_ff[SIS_C_COPY] |=> cause_ff[SIS_C_COPY])
		else $error("copy toggle did not set cause 5");

	emph_cause_a: assert property ( // RULE7
		live_ff && $changed(rx_flags.preemph_bit)
		&& !mask_ff[SIS_C_EMPH] |=> cause_ff[SIS_C_EMPH])
		else $error("emphasis toggle did not set cause 6");

	rate_cause_a: assert property ( // RULE8
		live_ff && $changed(rx_flags.recovered_rate_code)
		&& !mask_ff[SIS_C_RATE] |=> cause_ff[SIS_C_RATE])
		else $error("rate change did not set cause 7");

	status_nonlin_a: assert property ( // RULE9
		rd_status |=> reg_rdata_ff[SIS_F_NONLIN]
		== $past(rx_flags.nonlinear_bit))
		else $error("status bit 0 wrong");

	status_sync_a: assert property ( // RULE10
		rd_status |=> reg_rdata_ff[SIS_F_SYNC] == $past(rx_flags.sync_detect))
		else $error("status bit 1 wrong");

	status_copy_a: assert property ( // RULE11
		rd_status |=> reg_rdata_ff[SIS_F_COPY]
		== $past(rx_flags.copy_permit_bit))
		else $error("status bit 2 wrong");

	status_emph_a: assert property ( // RULE12
		rd_status |=> reg_rdata_ff[SIS_F_EMPH] == $past(rx_flags.preemph_bit))
		else $error("status bit 3 wrong");

	mask_block_a: assert property ( // RULE13
		mask_ff[SIS_C_INVALID] && !cause_ff[SIS_C_INVALID]
		|=> !cause_ff[SIS_C_INVALID])
		else $error("masked event set its cause");

	status_lock_a: assert property ( // RULE14
		rd_status |=> reg_rdata_ff[SIS_F_UNLOCK]
		== $past(rx_flags.unlock_flag) && !reg_rdata_ff[7])
		else $error("status unlock bit wrong");

	status_rate_a: assert property ( // RULE15
		rd_status |=> reg_rdata_ff[SIS_F_RATE_HI:SIS_F_RATE_LO]
		== $past(rx_flags.recovered_rate_code))
		else $error("status rate code wrong");

	irq_level_a: assert property ( // RULE17
		irq_n_ff == !(|(cause_ff & ~$past(mask_ff))))
		else $error("interrupt level disagrees with causes");

	read_clear_a: assert property ( // RULE17
		rd_cause && (ev == 8'h00) |=> (cause_ff == SIS_CAUSE_RST) && irq_n_ff)
		else $error("cause read did not clear");

	no_toggle_a: assert property ( // RULE18
		live_ff && $stable(rx_flags) |-> (chg == '0))
		else $error("toggle seen without a change");

	lock_read_c: cover property (
		ev[SIS_C_LOCK] ##1 !irq_n_ff ##[1:8] rd_cause ##1 irq_n_ff);
	multi_cause_c: cover property (
		cause_ff[SIS_C_RATE] && cause_ff[SIS_C_COPY] && !irq_n_ff);
	mask_write_c: cover property (
		wr_mask ##1 (mask_ff != SIS_MASK_RST) ##[1:8] ev[SIS_C_INVALID]);
	set_on_clear_c: cover property (rd_cause && (ev != 8'h00));

endmodule
